// >>> lmds_defs.vh
// constants for the long multiply, divide and saturate datapath
`ifndef LMDS_DEFS_VH
`define LMDS_DEFS_VH

// ----------------------------------------------------------------
// operation codes
// ----------------------------------------------------------------
`define LMDS_OP_W        4
`define LMDS_OP_NOP      4'h0
`define LMDS_OP_UMUL     4'h1
`define LMDS_OP_UMAC     4'h2
`define LMDS_OP_SMUL     4'h3
`define LMDS_OP_SMAC     4'h4
`define LMDS_OP_SIGNED_DIVIDE     4'h5
`define LMDS_OP_UNSIGNED_DIVIDE     4'h6
`define LMDS_OP_SIGNED_SATURATE     4'h7
`define LMDS_OP_UNSIGNED_SATURATE     4'h8
`define LMDS_OP_STWR     4'h9
`define LMDS_OP_STRD     4'ha

// ----------------------------------------------------------------
// status word layout and reset values
// ----------------------------------------------------------------
`define LMDS_STAT_SAT_BIT 27
`define LMDS_SAT_RST      1'b0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define LMDS_DIV_CYCLES   32
`define LMDS_MUL_CYCLES   1

`endif

// >>> lmds_divider.v
// radix-2 restoring divider for signed and unsigned 32-bit division
`timescale 1ns/1ps
`include "lmds_defs.vh"
module lmds_divider #(
	parameter WIDTH = 32
) (
	input  wire             sys_clk,
	input  wire             rst,
	input  wire             start,
	input  wire             isSigned,
	input  wire [WIDTH-1:0] dividend,
	input  wire [WIDTH-1:0] divisor,
	output reg              busy,
	output reg              done,
	output reg  [WIDTH-1:0] quotient
);

	reg  [WIDTH-1:0] quo_ff;
	reg  [WIDTH-1:0] rem_ff;
	reg  [WIDTH-1:0] dvs_ff;
	reg  [5:0]       cnt_ff;
	reg              neg_ff;
	reg              zero_ff;
	wire [WIDTH:0]   trial;
	wire [WIDTH-1:0] absA;
	wire [WIDTH-1:0] absB;

	assign absA  = (isSigned && dividend[WIDTH-1]) ? (~dividend + 1'b1)
		: dividend;
	assign absB  = (isSigned && divisor[WIDTH-1]) ? (~divisor + 1'b1)
		: divisor;
	assign trial = {rem_ff, quo_ff[WIDTH-1]} - {1'b0, dvs_ff};

	// ----------------------------------------------------------------
	// iteration
	// ----------------------------------------------------------------
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			quo_ff   <= {WIDTH{1'b0}};
			rem_ff   <= {WIDTH{1'b0}};
			dvs_ff   <= {WIDTH{1'b0}};
			cnt_ff   <= 6'h00;
			neg_ff   <= 1'b0;
			zero_ff  <= 1'b0;
			busy     <= 1'b0;
			done     <= 1'b0;
			quotient <= {WIDTH{1'b0}};
		end else begin
			done <= 1'b0;
			if (start && !busy) begin
				// magnitudes divide, sign fixed at end: truncation to zero
				quo_ff  <= absA;
				rem_ff  <= {WIDTH{1'b0}};
				dvs_ff  <= absB;
				neg_ff  <= isSigned && (dividend[WIDTH-1] ^ divisor[WIDTH-1]);
				zero_ff <= (divisor == {WIDTH{1'b0}});
				cnt_ff  <= 6'd`LMDS_DIV_CYCLES;
				busy    <= 1'b1;
			end else if (busy) begin
				if (trial[WIDTH]) begin
					rem_ff <= {rem_ff[WIDTH-2:0], quo_ff[WIDTH-1]};
					quo_ff <= {quo_ff[WIDTH-2:0], 1'b0};
				end else begin
					rem_ff <= trial[WIDTH-1:0];
					quo_ff <= {quo_ff[WIDTH-2:0], 1'b1};
				end
				cnt_ff <= cnt_ff - 6'h01;
				if (cnt_ff == 6'h01) begin
					busy <= 1'b0;
					done <= 1'b1;
					if (zero_ff)
						quotient <= {WIDTH{1'b0}};
					else if (neg_ff)
						quotient <= ~(trial[WIDTH] ? {quo_ff[WIDTH-2:0], 1'b0}
							: {quo_ff[WIDTH-2:0], 1'b1}) + 1'b1;
					else
						quotient <= trial[WIDTH] ? {quo_ff[WIDTH-2:0], 1'b0}
							: {quo_ff[WIDTH-2:0], 1'b1};
				end
			end
		end
	end

endmodule // lmds_divider

// >>> lmds_unit.v
// long multiply, divide and saturate execution datapath
`timescale 1ns/1ps
`include "lmds_defs.vh"
module lmds_unit #(
	parameter WIDTH = 32,
	parameter RIDX  = 4
) (
	input  wire              sys_clk,
	input  wire              rst,
	input  wire              opValid,
	input  wire [3:0]        opCode,
	input  wire [WIDTH-1:0]  opA,
	input  wire [WIDTH-1:0]  opB,
	input  wire [WIDTH-1:0]  accLow,
	input  wire [WIDTH-1:0]  accHigh,
	input  wire [RIDX-1:0]   dstLowIdx,
	input  wire [RIDX-1:0]   dstHighIdx,
	input  wire [RIDX-1:0]   firstIdx,
	input  wire              dstPresent,
	input  wire [5:0]        satPos,
	input  wire              shiftArith,
	input  wire [4:0]        shiftAmt,
	input  wire              statusClear,
	output reg               opReady,
	output reg               wrLowEn,
	output reg  [RIDX-1:0]   wrLowIdx,
	output reg  [WIDTH-1:0]  wrLowData,
	output reg               wrHighEn,
	output reg  [RIDX-1:0]   wrHighIdx,
	output reg  [WIDTH-1:0]  wrHighData,
	output reg               flagsWrEn,
	output reg               satFlag
);

	// ----------------------------------------------------------------
	// saturation helpers
	// ----------------------------------------------------------------
	// signed clamp to n bits, n in 1..32
	function [WIDTH-1:0] satSigned;
		input [WIDTH-1:0] v;
		input [5:0]       n;
		reg signed [WIDTH:0] hi;
		reg signed [WIDTH:0] lo;
		reg signed [WIDTH:0] sv;
		begin
			hi = ({{WIDTH{1'b0}}, 1'b1} << (n - 6'd1)) - 1;
			lo = -({{WIDTH{1'b0}}, 1'b1} << (n - 6'd1));
			sv = {v[WIDTH-1], v};
			if (sv > hi)
				satSigned = hi[WIDTH-1:0];
			else if (sv < lo)
				satSigned = lo[WIDTH-1:0];
			else
				satSigned = v;
		end
	endfunction

	// source read as signed, clamped to 0..2^n-1, n in 0..31
	function [WIDTH-1:0] satUnsigned;
		input [WIDTH-1:0] v;
		input [5:0]       n;
		reg [WIDTH:0] hi;
		begin
			hi = ({{WIDTH{1'b0}}, 1'b1} << n) - 1;
			if (v[WIDTH-1])
				satUnsigned = {WIDTH{1'b0}};
			else if ({1'b0, v} > hi)
				satUnsigned = hi[WIDTH-1:0];
			else
				satUnsigned = v;
		end
	endfunction

	// ----------------------------------------------------------------
	// states
	// ----------------------------------------------------------------
	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_DIV  = 2'b10;

	reg  [1:0]         state_ff;
	reg  [1:0]         nxt_state;
	reg  [RIDX-1:0]    divDst_ff;

	wire               isUmul;
	wire               isSmul;
	wire               isMac;
	wire               isDiv;
	wire               isSsat;
	wire               isUsat;
	wire [2*WIDTH-1:0] uProd;
	wire [2*WIDTH-1:0] sProd;
	wire [2*WIDTH-1:0] accIn;
	wire [2*WIDTH-1:0] mulRes;
	wire [WIDTH-1:0]   shifted;
	wire signed [WIDTH-1:0] shArith;
	wire [WIDTH-1:0]   satRes;
	wire               satHit;
	wire               divBusy;
	wire               divDone;
	wire [WIDTH-1:0]   divQuo;
	wire               accept;

	assign accept = opValid && (state_ff == ST_IDLE);
	assign isUmul = (opCode == `LMDS_OP_UMUL) || (opCode == `LMDS_OP_UMAC);
	assign isSmul = (opCode == `LMDS_OP_SMUL) || (opCode == `LMDS_OP_SMAC);
	assign isMac  = (opCode == `LMDS_OP_UMAC) || (opCode == `LMDS_OP_SMAC);
	assign isDiv  = (opCode == `LMDS_OP_SIGNED_DIVIDE) || (opCode == `LMDS_OP_UNSIGNED_DIVIDE);
	assign isSsat = (opCode == `LMDS_OP_SIGNED_SATURATE);
	assign isUsat = (opCode == `LMDS_OP_UNSIGNED_SATURATE);

	// ----------------------------------------------------------------
	// multiply and accumulate
	// ----------------------------------------------------------------
	assign uProd  = {{WIDTH{1'b0}}, opA} * {{WIDTH{1'b0}}, opB};
	assign sProd  = $signed({{WIDTH{opA[WIDTH-1]}}, opA})
		* $signed({{WIDTH{opB[WIDTH-1]}}, opB});
	// 64-bit wraparound add is identical for signed and unsigned
	assign accIn  = isMac ? {accHigh, accLow} : {2*WIDTH{1'b0}};
	assign mulRes = (isSmul ? sProd : uProd) + accIn;

	// ----------------------------------------------------------------
	// shift then saturate
	// ----------------------------------------------------------------
	// arithmetic shift kept on its own signed net: inside a mixed ternary
	// the signed operand would turn unsigned and shift in zeros
	assign shArith = $signed(opB) >>> shiftAmt;
	assign shifted = shiftArith ? shArith : (opB << shiftAmt);
	assign satRes  = isSsat ? satSigned(shifted, satPos)
		: satUnsigned(shifted, satPos);
	assign satHit  = (satRes != shifted);

	// ----------------------------------------------------------------
	// divider
	// ----------------------------------------------------------------
	lmds_divider #(
		.WIDTH    (WIDTH)
	) u_div (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.start    (accept && isDiv),
		.isSigned (opCode == `LMDS_OP_SIGNED_DIVIDE),
		.dividend (opA),
		.divisor  (opB),
		.busy     (divBusy),
		.done     (divDone),
		.quotient (divQuo)
	);

	// ----------------------------------------------------------------
	// control
	// ----------------------------------------------------------------
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (accept && isDiv)
					nxt_state = ST_DIV;
			end
			ST_DIV: begin
				if (divDone)
					nxt_state = ST_IDLE;
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_ff   <= ST_IDLE;
			divDst_ff  <= {RIDX{1'b0}};
			opReady    <= 1'b0;
			wrLowEn    <= 1'b0;
			wrLowIdx   <= {RIDX{1'b0}};
			wrLowData  <= {WIDTH{1'b0}};
			wrHighEn   <= 1'b0;
			wrHighIdx  <= {RIDX{1'b0}};
			wrHighData <= {WIDTH{1'b0}};
			flagsWrEn  <= 1'b0;
			satFlag    <= `LMDS_SAT_RST;
		end else begin
			state_ff  <= nxt_state;
			opReady   <= (nxt_state == ST_IDLE);
			wrLowEn   <= 1'b0;
			wrHighEn  <= 1'b0;
			// no operation here touches the condition flags
			flagsWrEn <= 1'b0;
			if (accept) begin
				case (opCode)
					`LMDS_OP_UMUL, `LMDS_OP_UMAC,
					`LMDS_OP_SMUL, `LMDS_OP_SMAC: begin
						// distinct register indices assumed
						wrLowEn    <= 1'b1;
						wrLowIdx   <= dstLowIdx;
						wrLowData  <= mulRes[WIDTH-1:0];
						wrHighEn   <= 1'b1;
						wrHighIdx  <= dstHighIdx;
						wrHighData <= mulRes[2*WIDTH-1:WIDTH];
					end
					`LMDS_OP_SIGNED_DIVIDE, `LMDS_OP_UNSIGNED_DIVIDE: begin
						divDst_ff <= dstPresent ? dstLowIdx : firstIdx;
					end
					`LMDS_OP_SIGNED_SATURATE, `LMDS_OP_UNSIGNED_SATURATE: begin
						// positions and shift ranges come legal
						wrLowEn   <= 1'b1;
						wrLowIdx  <= dstLowIdx;
						wrLowData <= satRes;
					end
					`LMDS_OP_STRD: begin
						wrLowEn   <= 1'b1;
						wrLowIdx  <= dstLowIdx;
						wrLowData <= {{(WIDTH-1-`LMDS_STAT_SAT_BIT){1'b0}},
							satFlag, {`LMDS_STAT_SAT_BIT{1'b0}}};
					end
					default: begin
					end
				endcase
			end
			if (divDone) begin
				wrLowEn   <= 1'b1;
				wrLowIdx  <= divDst_ff;
				wrLowData <= divQuo;
			end
			// set wins over clear
			if (accept && (isSsat || isUsat) && satHit)
				satFlag <= 1'b1;
			else if (accept && (opCode == `LMDS_OP_STWR) && statusClear)
				satFlag <= 1'b0;
		end
	end

endmodule // lmds_unit

// >>> lmds_unit_assertions.sv
// concurrent checks on the ports of the datapath unit
`timescale 1ns/1ps
`include "lmds_defs.vh"
module lmds_unit_checker #(
	parameter WIDTH = 32,
	parameter RIDX  = 4
) (
	input wire logic             sys_clk,
	input wire logic             rst,
	input wire logic             opValid,
	input wire logic [3:0]       opCode,
	input wire logic [WIDTH-1:0] opA,
	input wire logic [WIDTH-1:0] opB,
	input wire logic [WIDTH-1:0] accLow,
	input wire logic [WIDTH-1:0] accHigh,
	input wire logic [RIDX-1:0]  firstIdx,
	input wire logic             dstPresent,
	input wire logic             statusClear,
	input wire logic             opReady,
	input wire logic             wrLowEn,
	input wire logic [RIDX-1:0]  wrLowIdx,
	input wire logic [WIDTH-1:0] wrLowData,
	input wire logic             wrHighEn,
	input wire logic [WIDTH-1:0] wrHighData,
	input wire logic             flagsWrEn,
	input wire logic             satFlag
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	wire logic take = opValid && opReady;
	wire logic isDiv = opCode == `LMDS_OP_SIGNED_DIVIDE || opCode == `LMDS_OP_UNSIGNED_DIVIDE;
	wire logic isSat = opCode == `LMDS_OP_SIGNED_SATURATE || opCode == `LMDS_OP_UNSIGNED_SATURATE;
	umul_result_a: assert property (
		take && opCode == `LMDS_OP_UMUL |=> wrLowEn && wrHighEn &&
		{wrHighData, wrLowData} == {32'h0, $past(opA)} * {32'h0, $past(opB)})
		else $error("unsigned multiply wrong");
	smac_result_a: assert property (
		take && opCode == `LMDS_OP_SMAC |=> $signed({wrHighData, wrLowData})
		== $signed({$past(accHigh), $past(accLow)}) +
		$signed($past(opA)) * $signed($past(opB)))
		else $error("signed accumulate wrong");
	flags_kept_a: assert property (!flagsWrEn)
		else $error("condition flags written");
	div_latency_a: assert property (
		take && isDiv |=> !opReady ##33 wrLowEn)
		else $error("quotient late or early");
	div_zero_a: assert property (
		take && isDiv && opB == 32'h0 |-> ##34 wrLowData == 32'h0)
		else $error("divide by zero not zero");
	div_writeback_a: assert property (
		take && isDiv && !dstPresent |-> ##34 wrLowIdx == $past(firstIdx, 34))
		else $error("quotient index wrong");
	sat_set_a: assert property (
		$rose(satFlag) |-> $past(take && isSat))
		else $error("flag set without saturate");
	sat_clear_a: assert property (
		$fell(satFlag) |-> $past(take && opCode == `LMDS_OP_STWR && statusClear))
		else $error("flag cleared without status write");
	status_read_a: assert property (
		take && opCode == `LMDS_OP_STRD |=> wrLowEn &&
		wrLowData[`LMDS_STAT_SAT_BIT] == satFlag)
		else $error("status read flag wrong");
endmodule // lmds_unit_checker

bind lmds_unit lmds_unit_checker #(.WIDTH(WIDTH), .RIDX(RIDX)) u_chk (.*);

// >>> lmds_regfile_model.sv
// register file model with write forwarding for the accumulator reads
`timescale 1ns/1ps
module lmds_regfile_model (
	input  wire logic        sys_clk,
	input  wire logic        wrLowEn,
	input  wire logic [3:0]  wrLowIdx,
	input  wire logic [31:0] wrLowData,
	input  wire logic        wrHighEn,
	input  wire logic [3:0]  wrHighIdx,
	input  wire logic [31:0] wrHighData,
	input  wire logic [3:0]  dstLowIdx,
	input  wire logic [3:0]  dstHighIdx,
	output logic      [31:0] accLow,
	output logic      [31:0] accHigh
);
	logic [31:0] regs [0:15];
	function automatic logic [31:0] fwd(input logic [3:0] idx);
		if (wrHighEn && wrHighIdx == idx)
			return wrHighData;
		if (wrLowEn && wrLowIdx == idx)
			return wrLowData;
		return regs[idx];
	endfunction
	initial for (int i = 0; i < 16; i++) regs[i] = 32'h0;
	// both halves land in the same cycle; the pair is always distinct
	always @(posedge sys_clk) begin
		if (wrLowEn)
			regs[wrLowIdx] <= wrLowData;
		if (wrHighEn)
			regs[wrHighIdx] <= wrHighData;
	end
	always_comb begin
		accLow = fwd(dstLowIdx);
		accHigh = fwd(dstHighIdx);
	end
endmodule // lmds_regfile_model

// >>> lmds_unit_bench.sv
// self-checking bench for the long multiply, divide and saturate unit
`timescale 1ns/1ps
`include "lmds_defs.vh"
module lmds_unit_bench;
	logic        sys_clk = 0;
	logic        rst = 1;
	logic        opValid = 0;
	logic [3:0]  opCode = 0;
	logic [31:0] opA = 0;
	logic [31:0] opB = 0;
	logic [3:0]  dstLowIdx = 0;
	logic [3:0]  dstHighIdx = 1;
	logic [3:0]  firstIdx = 0;
	logic        dstPresent = 0;
	logic [5:0]  satPos = 0;
	logic        shiftArith = 0;
	logic [4:0]  shiftAmt = 0;
	logic        statusClear = 0;
	logic        opReady, wrLowEn, wrHighEn, flagsWrEn, satFlag, mSat;
	logic [3:0]  wrLowIdx, wrHighIdx;
	logic [31:0] wrLowData, wrHighData, accLow, accHigh;
	logic [31:0] m [0:15];
	int          miscompares = 0;
	int          comparisons = 0;
	int          seed = 90054;
	int          cycles = 0;
	lmds_unit u_lmds_unit (.*);
	lmds_regfile_model u_lmds_regfile_model (.*);
	always #5 sys_clk = ~sys_clk;
	task automatic test_done();
		if (miscompares == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares++;
			test_done();
		end
	end
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	function automatic logic [31:0] pick();
		case ({$random(seed)} % 4)
		0: return 32'h8000_0000;
		1: return 32'hffff_ffff;
		2: return {$random(seed)} % 4;
		default: return $random(seed);
		endcase
	endfunction
	task automatic doOp(input logic [3:0] op);
		logic [63:0] p;
		longint      x, mn, mx;
		logic [31:0] a, b, sh;
		logic [3:0]  lo, hi, dst;
		logic        div;
		int          k, n;
		a = pick();
		b = pick();
		lo = 4'({$random(seed)} % 13);
		hi = 4'((lo + 1 + {$random(seed)} % 12) % 13);
		n = (op == `LMDS_OP_SIGNED_SATURATE) + {$random(seed)} % 32;
		shiftArith = $random(seed);
		shiftAmt = 5'(shiftArith + {$random(seed)} % (32 - shiftArith));
		statusClear = $random(seed);
		dstPresent = $random(seed);
		div = op == `LMDS_OP_SIGNED_DIVIDE || op == `LMDS_OP_UNSIGNED_DIVIDE;
		dst = (div && !dstPresent) ? hi : lo;
		if (op == `LMDS_OP_STRD)
			dst = 4'he;
		p = 0;
		case (op)
		`LMDS_OP_UMUL: p = {32'h0, a} * {32'h0, b};
		`LMDS_OP_UMAC: p = {m[hi], m[lo]} + {32'h0, a} * {32'h0, b};
		`LMDS_OP_SMUL: p = $signed(a) * $signed(b);
		`LMDS_OP_SMAC: p = $signed({m[hi], m[lo]}) + $signed(a) * $signed(b);
		`LMDS_OP_SIGNED_DIVIDE: p = (b == 0) ? 0 :
			longint'($signed(a)) / longint'($signed(b));
		`LMDS_OP_UNSIGNED_DIVIDE: p = (b == 0) ? 0 : a / b;
		`LMDS_OP_STWR: mSat = mSat & !statusClear;
		`LMDS_OP_SIGNED_SATURATE, `LMDS_OP_UNSIGNED_SATURATE: begin
			if (shiftArith)
				sh = $signed(b) >>> shiftAmt;
			else
				sh = b << shiftAmt;
			x = $signed(sh);
			mx = (longint'(1) <<< (n - (op == `LMDS_OP_SIGNED_SATURATE))) - 1;
			mn = (op == `LMDS_OP_SIGNED_SATURATE) ? -mx - 1 : 0;
			p = (x < mn) ? mn : (x > mx) ? mx : x;
			mSat = mSat | (p != x);
		end
		default: ;
		endcase
		opCode = op;
		opA = a;
		opB = b;
		dstLowIdx = dst;
		dstHighIdx = hi;
		firstIdx = hi;
		satPos = 6'(n);
		opValid = 1;
		for (k = 0; k < 40 && opReady !== 1'b1; k++)
			@(posedge sys_clk) #1;
		@(posedge sys_clk) #1;
		if (div)
			opValid = 0;
		for (k = 0; k < 40 && div && wrLowEn !== 1'b1; k++)
			@(posedge sys_clk) #1;
		chk(k, div ? `LMDS_DIV_CYCLES + 1 : 0);
		chk(flagsWrEn, 0);
		chk(satFlag, mSat);
		if (op == `LMDS_OP_NOP || op == `LMDS_OP_STWR) begin
			chk(wrLowEn, 0);
		end else if (op == `LMDS_OP_STRD) begin
			chk({wrLowEn, wrLowIdx, wrLowData[27]}, {1'b1, dst, mSat});
		end else begin
			chk({wrLowEn, wrLowIdx, wrLowData}, {1'b1, dst, p[31:0]});
			m[dst] = p[31:0];
		end
		if (op >= `LMDS_OP_UMUL && op <= `LMDS_OP_SMAC) begin
			chk({wrHighEn, wrHighIdx, wrHighData}, {1'b1, hi, p[63:32]});
			m[hi] = p[63:32];
		end
	endtask
	initial begin
		mSat = 0;
		for (int i = 0; i < 16; i++) m[i] = 32'h0;
		repeat (10) @(posedge sys_clk);
		#1 rst = 0;
		for (int i = 0; i < 11; i++) doOp(4'(i));
		repeat (300) doOp(4'({$random(seed)} % 11));
		test_done();
	end
endmodule // lmds_unit_bench
